// [bench/mpc_pin_world.sv]
// Model of the pins outside the block
`timescale 1ns/100ps
`default_nettype none
module mpc_pin_world (
  input wire logic [mpc_pkg::NPIN-1:0] pin_out,
  input wire logic [mpc_pkg::NPIN-1:0] pin_oe,
  input wire logic [mpc_pkg::NPIN-1:0] pin_pullup_en,
  input wire logic [mpc_pkg::NPIN-1:0] ext_lvl,
  output logic [mpc_pkg::NPIN-1:0] pin_in
);
  // Released pins show pull-up or outside level
  always_comb
  begin
    for (int i = 0; i < mpc_pkg::NPIN; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pullup_en[i] | ext_lvl[i]);
    end
  end
endmodule
`default_nettype wire

// [bench/mpc_port_ctrl_bench.sv]
// Testbench for the port pin control block
`timescale 1ns/100ps
`default_nettype none
module mpc_port_ctrl_bench;
  logic clk_sys, rst_n, reg_wr, reg_rd, rd_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, alt_oe, alt_out, alt_in;
  logic [mpc_pkg::NPIN-1:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_ttl_sel, pin_analog_sel, ext_lvl;
  logic [127:0] rnd;
  logic [7:0] r [13];
  logic [7:0] exp_q [$];
  int fail_count, checked, p;
  mpc_port_ctrl mpc_port_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_ttl_sel(pin_ttl_sel), .pin_analog_sel(pin_analog_sel), .alt_oe(alt_oe),
    .alt_out(alt_out), .alt_in(alt_in));
  mpc_pin_world mpc_pin_world_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // ----------------------------------------
  // Bus tasks and compares
  // ----------------------------------------
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] e, input string what);
    checked++;
    if (got !== e)
    begin
      fail_count++;
      $display("mismatch at %0t %s got %h want %h", $time, what, got, e);
    end
  endtask
  task chk_pin(input logic [7:0] got, input logic [7:0] e);
    cmp(got, e, "pins");
  endtask
  task chk_rd(input logic [7:0] got, input logic [7:0] e);
    cmp(got, e, "read");
  endtask
  task end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Read data monitor and clock
  // ----------------------------------------
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys)
  begin
    if (rd_seen === 1'b1)
      chk_rd(reg_rdata, exp_q.pop_front());
  end
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #40000;
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_seen = 1'b0;
    alt_oe = 8'h00;
    alt_out = 8'h00;
    fail_count = 0;
    checked = 0;
    rnd[127:96] = $urandom(13);
    rnd[95:0] = {$urandom, $urandom, $urandom};
    ext_lvl = rnd[103:0];
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk_pin(pin_oe[87:80], 8'h01);
    for (p = 0; p < 13; p++)
    begin
      rd(8'h10 | p[7:0], 8'hff);
      rd(8'h50 | p[7:0], mpc_pkg::CAP_MODE[p]);
      chk_pin(pin_analog_sel[p*8 +: 8], p == 12 ? 8'h7f : mpc_pkg::CAP_MODE[p]);
    end
    rd(8'h60, 8'h7f);
    rd(8'h61, 8'h00);
    rd(8'h7f, 8'h00);
    rd(8'h02, ext_lvl[23:16]);
    rd(8'h00, {3'b000, ext_lvl[4:0]});
    for (p = 0; p < 13; p++) wr(8'h50 | p[7:0], 8'h00);
    wr(8'h60, 8'h00);
    for (p = 0; p < 13; p++)
    begin
      r[p] = 8'($urandom);
      wr(8'h10 | p[7:0], r[p]);
      rd(8'h10 | p[7:0], r[p] | ~mpc_pkg::CAP_DIR[p]);
      chk_pin(pin_oe[p*8 +: 8], (~r[p] & mpc_pkg::CAP_DIR[p]) | mpc_pkg::CAP_FIXOUT[p]);
    end
    for (p = 0; p < 13; p++)
    begin
      wr(8'h20 | p[7:0], 8'hff);
      chk_pin(pin_pullup_en[p*8 +: 8], mpc_pkg::CAP_PULL[p] & (r[p] | ~mpc_pkg::CAP_DIR[p]));
      wr(8'h30 | p[7:0], 8'hff);
      chk_pin(pin_ttl_sel[p*8 +: 8], mpc_pkg::CAP_TTL[p]);
    end
    wr(8'h50, 8'hff);
    chk_pin(pin_analog_sel[7:0], 8'he0);
    wr(8'h5c, 8'hff);
    chk_pin(pin_analog_sel[103:96], 8'h00);
    wr(8'h60, 8'h55);
    chk_pin(pin_analog_sel[103:96], 8'h55);
    wr(8'h60, 8'h00);
    wr(8'h50, 8'h00);
    for (p = 0; p < 13; p++) wr(8'h10 | p[7:0], 8'h00);
    for (p = 0; p < 13; p++) wr(8'h20 | p[7:0], 8'h00);
    wr(8'h41, 8'hff);
    wr(8'h01, 8'hff);
    chk_pin(pin_oe[15:8], ~mpc_pkg::CAP_ODRN[1]);
    wr(8'h01, 8'h00);
    chk_pin(pin_oe[15:8], 8'hff);
    chk_pin(pin_out[15:8], 8'h00);
    wr(8'h41, 8'h00);
    for (p = 0; p < 8; p++)
    begin
      @(posedge clk_sys);
      alt_oe <= 8'h01 << p;
      alt_out <= 8'hff;
      wr(8'h61, 8'h00);
      chk_pin({5'h0, pin_out[mpc_pkg::RED_PRI[p]], pin_out[mpc_pkg::RED_SEC[p]], alt_in[p]}, 8'h05);
      wr(8'h61, 8'h01 << p);
      chk_pin({5'h0, pin_out[mpc_pkg::RED_PRI[p]], pin_out[mpc_pkg::RED_SEC[p]], alt_in[p]}, 8'h03);
    end
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule
`default_nettype wire

// [bench/mpc_port_ctrl_chk.sv]
// Concurrent checks on the port pin control ports
`timescale 1ns/100ps
`default_nettype none
module mpc_port_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [mpc_pkg::AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [mpc_pkg::NPIN-1:0] pin_oe,
  input wire logic [mpc_pkg::NPIN-1:0] pin_pullup_en,
  input wire logic [mpc_pkg::NPIN-1:0] pin_ttl_sel,
  input wire logic [mpc_pkg::NPIN-1:0] pin_analog_sel
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pull_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pin_pullup_en & pin_oe) == '0) else $error("pull-up on a driven pin");
  a_analog_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pin_analog_sel & (pin_oe | pin_pullup_en)) == '0) else $error("analog pin driven or pulled");
  a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == 8'h10 |-> ##2 pin_oe[4:0] == ~$past(reg_wdata[4:0], 2))
    else $error("direction write not seen on enables");
  a_port12_inputs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_oe[76:73] == 4'h0 && pin_pullup_en[76:73] == 4'h0) else $error("input-only bit driven");
  a_port13_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_oe[87:80] == 8'h01) else $error("port 13 enables wrong");
  a_short_ports: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pin_oe[63] && !pin_oe[103]) else $error("missing bit driven");
  a_ttl_capable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_ttl_sel[7:0] == 8'h00 && pin_ttl_sel[103:96] == 8'h00) else $error("ttl on plain pin");
  a_reset_pins: assert property (@(posedge clk_sys)
    !rst_n |-> pin_oe == (104'h1 << 80) && pin_pullup_en == '0 && pin_analog_sel[102:96] == 7'h7f)
    else $error("pins wrong in reset");
  a_cfg15_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == 8'h60 |-> ##2 pin_analog_sel[102:96] == $past(reg_wdata[6:0], 2))
    else $error("port 15 analog select wrong");
endmodule
bind mpc_port_ctrl mpc_port_ctrl_chk mpc_port_ctrl_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .pin_ttl_sel(pin_ttl_sel), .pin_analog_sel(pin_analog_sel));
`default_nettype wire

// [logic/mpc_pin_cell.sv]
// One port's pin drive, pull-up, threshold and analog control
`timescale 1ns/100ps
`default_nettype none
module mpc_pin_cell #(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] DIRC = 8'hff,
  parameter logic [7:0] PULLC = 8'hff,
  parameter logic [7:0] TTLC = 8'h00,
  parameter logic [7:0] ODC = 8'h00,
  parameter logic [7:0] FIXOUT = 8'h00
)(
  input wire logic [7:0] latch,
  input wire logic [7:0] dir_in,
  input wire logic [7:0] pull,
  input wire logic [7:0] ttl,
  input wire logic [7:0] odrn,
  input wire logic [7:0] ana,
  input wire logic [7:0] alt_en,
  input wire logic [7:0] alt_val,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu,
  output logic [7:0] pin_ttl,
  output logic [7:0] pin_ana,
  output logic [7:0] rd_view
);
  logic [7:0] is_in;
  logic [7:0] val;
  // --------------------------------------------------
  // Effective direction and drive
  // --------------------------------------------------
  assign is_in = ((DIRC & dir_in) | (~DIRC & ~FIXOUT)) & IMPL;
  assign val = (alt_en & alt_val) | (~alt_en & latch);
  assign pin_out = val & IMPL;
  assign pin_oe = IMPL & ~is_in & ~ana & ~(ODC & odrn & val);
  assign pin_pu = PULLC & pull & is_in & ~ana;
  assign pin_ttl = TTLC & ttl;
  assign pin_ana = ana & IMPL;
  assign rd_view = IMPL & ((is_in & ~ana & pin_in) | (~is_in & latch));
endmodule
`default_nettype wire

// [logic/mpc_pkg.sv]
// Constants shared by the port pin control block
package mpc_pkg;
  localparam int NPORT = 13;
  localparam int PW = 8;
  localparam int NPIN = NPORT * PW;
  localparam int NRED = 8;
  localparam int AW = 8;
  // --------------------------------------------------
  // Register groups, high nibble of the address; single registers, full address
  // --------------------------------------------------
  localparam logic [3:0] GRP_DATA = 4'h0;
  localparam logic [3:0] GRP_DIR = 4'h1;
  localparam logic [3:0] GRP_PULL = 4'h2;
  localparam logic [3:0] GRP_TTL = 4'h3;
  localparam logic [3:0] GRP_ODRN = 4'h4;
  localparam logic [3:0] GRP_MODE = 4'h5;
  localparam logic [AW-1:0] OFS_ANALOG_CFG = 8'h60;
  localparam logic [AW-1:0] OFS_REDIR = 8'h61;
  // --------------------------------------------------
  // Reset values
  // --------------------------------------------------
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ANALOG_CFG = 8'h7f;
  localparam logic [7:0] RST_REDIR = 8'h00;
  // --------------------------------------------------
  // Per-port capability masks, index 0 is port 3
  // --------------------------------------------------
  localparam logic [7:0] CAP_IMPL [NPORT] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h7f, 8'hff, 8'hff, 8'h81, 8'hff, 8'h7f};
  localparam logic [7:0] CAP_DIR [NPORT] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h7f, 8'hff, 8'he1, 8'h00, 8'hff, 8'h7f};
  localparam logic [7:0] CAP_PULL [NPORT] = '{8'hff, 8'hff, 8'hff, 8'hf0, 8'hff, 8'hff, 8'hff,
    8'h7f, 8'hff, 8'he1, 8'h00, 8'hff, 8'h7f};
  localparam logic [7:0] CAP_TTL [NPORT] = '{8'h00, 8'h18, 8'h38, 8'h00, 8'h00, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h00};
  localparam logic [7:0] CAP_ODRN [NPORT] = '{8'h00, 8'h38, 8'h3d, 8'h0f, 8'h12, 8'h07, 8'h40,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 8'h00};
  localparam logic [7:0] CAP_MODE [NPORT] = '{8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'he0, 8'h01, 8'h00, 8'h80, 8'h00};
  localparam logic [7:0] CAP_FIXOUT [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam int PORT_ANALOG_PORT_CONFIG = 12;
  // --------------------------------------------------
  // Redirectable functions: primary and secondary pin
  // --------------------------------------------------
  localparam logic [6:0] RED_PRI [NRED] = '{7'd88, 7'd89, 7'd14, 7'd0, 7'd1, 7'd88, 7'd89, 7'd38};
  localparam logic [6:0] RED_SEC [NRED] = '{7'd1, 7'd21, 7'd22, 7'd23, 7'd94, 7'd44, 7'd45, 7'd64};
endpackage

// [logic/mpc_port_ctrl.sv]
// Port pin control for ports 3 to 15
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Each bidirectional bit has its own software direction bit.
// - Pull-up connects only when requested and the bit is an input.
// - Analog-capable pins switch digital or analog via a mode control bit.
// - Port 15 pins choose digital or analog via the analog port config.
// - Redirectable functions use the secondary pin only when its redirection bit is set.
// - Listed inputs may select a TTL-threshold input buffer.
// - Listed outputs may switch to open-drain, pulling low only.
// - Port 12 has four bidirectional and four input-only bits.
// - Port 13 has one fixed output bit and one fixed input bit.
// - Ports 10 and 15 have seven bits, port 13 two, the others eight.
// - Upper three bits of port 3 can be analog inputs.
module mpc_port_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [mpc_pkg::AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [mpc_pkg::NPIN-1:0] pin_in,
  output logic [mpc_pkg::NPIN-1:0] pin_out,
  output logic [mpc_pkg::NPIN-1:0] pin_oe,
  output logic [mpc_pkg::NPIN-1:0] pin_pullup_en,
  output logic [mpc_pkg::NPIN-1:0] pin_ttl_sel,
  output logic [mpc_pkg::NPIN-1:0] pin_analog_sel,
  input wire logic [mpc_pkg::NRED-1:0] alt_oe,
  input wire logic [mpc_pkg::NRED-1:0] alt_out,
  output logic [mpc_pkg::NRED-1:0] alt_in
);
  localparam int NP = mpc_pkg::NPORT;
  localparam logic [mpc_pkg::NPIN-1:0] RST_PIN_OE = {mpc_pkg::CAP_FIXOUT[12], mpc_pkg::CAP_FIXOUT[11],
    mpc_pkg::CAP_FIXOUT[10], mpc_pkg::CAP_FIXOUT[9], mpc_pkg::CAP_FIXOUT[8], mpc_pkg::CAP_FIXOUT[7],
    mpc_pkg::CAP_FIXOUT[6], mpc_pkg::CAP_FIXOUT[5], mpc_pkg::CAP_FIXOUT[4], mpc_pkg::CAP_FIXOUT[3],
    mpc_pkg::CAP_FIXOUT[2], mpc_pkg::CAP_FIXOUT[1], mpc_pkg::CAP_FIXOUT[0]};
  localparam logic [mpc_pkg::NPIN-1:0] RST_PIN_ANA = {mpc_pkg::RST_ANALOG_CFG, mpc_pkg::CAP_MODE[11],
    mpc_pkg::CAP_MODE[10], mpc_pkg::CAP_MODE[9], mpc_pkg::CAP_MODE[8], mpc_pkg::CAP_MODE[7],
    mpc_pkg::CAP_MODE[6], mpc_pkg::CAP_MODE[5], mpc_pkg::CAP_MODE[4], mpc_pkg::CAP_MODE[3],
    mpc_pkg::CAP_MODE[2], mpc_pkg::CAP_MODE[1], mpc_pkg::CAP_MODE[0]};

  logic [7:0] latch_q [NP];
  logic [7:0] dir_q [NP];
  logic [7:0] pull_q [NP];
  logic [7:0] ttl_q [NP];
  logic [7:0] odrn_q [NP];
  logic [7:0] port_mode_control_bits_q [NP];
  logic [7:0] analog_port_config_q;
  logic [7:0] peripheral_redirection_control_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] ana_eff [NP];
  logic [7:0] rd_view [NP];
  logic [mpc_pkg::NPIN-1:0] ovr_en;
  logic [mpc_pkg::NPIN-1:0] ovr_val;
  logic [mpc_pkg::NPIN-1:0] pin_out_d;
  logic [mpc_pkg::NPIN-1:0] pin_oe_d;
  logic [mpc_pkg::NPIN-1:0] pin_pu_d;
  logic [mpc_pkg::NPIN-1:0] pin_ttl_d;
  logic [mpc_pkg::NPIN-1:0] pin_ana_d;
  logic [mpc_pkg::NRED-1:0] alt_in_d;
  logic [mpc_pkg::NPIN-1:0] pin_out_q;
  logic [mpc_pkg::NPIN-1:0] pin_oe_q;
  logic [mpc_pkg::NPIN-1:0] pin_pu_q;
  logic [mpc_pkg::NPIN-1:0] pin_ttl_q;
  logic [mpc_pkg::NPIN-1:0] pin_ana_q;
  logic [mpc_pkg::NRED-1:0] alt_in_q;

  function automatic logic hit(input logic [mpc_pkg::AW-1:0] a, input logic [3:0] grp, input int p);
    hit = (a[7:4] == grp) && (a[3:0] == 4'(p));
  endfunction

  // --------------------------------------------------
  // Output latches
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        latch_q[p] <= mpc_pkg::RST_ZERO;
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_DATA, p))
          latch_q[p] <= reg_wdata & mpc_pkg::CAP_IMPL[p];
    end
  end

  // --------------------------------------------------
  // Direction, one bit per pin, 1 = input
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        dir_q[p] <= mpc_pkg::RST_DIR;
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_DIR, p))
          dir_q[p] <= reg_wdata | ~mpc_pkg::CAP_DIR[p];
    end
  end

  // --------------------------------------------------
  // Pull-up request
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        pull_q[p] <= mpc_pkg::RST_ZERO;
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_PULL, p))
          pull_q[p] <= reg_wdata & mpc_pkg::CAP_PULL[p];
    end
  end

  // --------------------------------------------------
  // Input threshold select
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        ttl_q[p] <= mpc_pkg::RST_ZERO;
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_TTL, p))
          ttl_q[p] <= reg_wdata & mpc_pkg::CAP_TTL[p];
    end
  end

  // --------------------------------------------------
  // Open-drain select
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        odrn_q[p] <= mpc_pkg::RST_ZERO;
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_ODRN, p))
          odrn_q[p] <= reg_wdata & mpc_pkg::CAP_ODRN[p];
    end
  end

  // --------------------------------------------------
  // Port mode control, 1 = analog
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < NP; p++)
        port_mode_control_bits_q[p] <= mpc_pkg::CAP_MODE[p];
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < NP; p++)
        if (hit(reg_addr, mpc_pkg::GRP_MODE, p))
          port_mode_control_bits_q[p] <= reg_wdata & mpc_pkg::CAP_MODE[p];
    end
  end

  // --------------------------------------------------
  // Analog port config and redirection control
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      analog_port_config_q <= mpc_pkg::RST_ANALOG_CFG;
    else if (reg_wr && reg_addr == mpc_pkg::OFS_ANALOG_CFG)
      analog_port_config_q <= reg_wdata & mpc_pkg::CAP_IMPL[mpc_pkg::PORT_ANALOG_PORT_CONFIG];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      peripheral_redirection_control_q <= mpc_pkg::RST_REDIR;
    else if (reg_wr && reg_addr == mpc_pkg::OFS_REDIR)
      peripheral_redirection_control_q <= reg_wdata;
  end

  // --------------------------------------------------
  // Effective analog selection
  // --------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < NP; p++)
      ana_eff[p] = port_mode_control_bits_q[p];
    ana_eff[mpc_pkg::PORT_ANALOG_PORT_CONFIG] = analog_port_config_q;
  end

  // --------------------------------------------------
  // Function redirection
  // --------------------------------------------------
  mpc_redirect u_redirect (
    .redir(peripheral_redirection_control_q),
    .alt_oe(alt_oe),
    .alt_out(alt_out),
    .pin_in(pin_in),
    .ovr_en(ovr_en),
    .ovr_val(ovr_val),
    .alt_in(alt_in_d)
  );

  // --------------------------------------------------
  // Pin cells
  // --------------------------------------------------
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    mpc_pin_cell #(
      .IMPL(mpc_pkg::CAP_IMPL[p]),
      .DIRC(mpc_pkg::CAP_DIR[p]),
      .PULLC(mpc_pkg::CAP_PULL[p]),
      .TTLC(mpc_pkg::CAP_TTL[p]),
      .ODC(mpc_pkg::CAP_ODRN[p]),
      .FIXOUT(mpc_pkg::CAP_FIXOUT[p])
    ) u_cell (
      .latch(latch_q[p]),
      .dir_in(dir_q[p]),
      .pull(pull_q[p]),
      .ttl(ttl_q[p]),
      .odrn(odrn_q[p]),
      .ana(ana_eff[p]),
      .alt_en(ovr_en[p*8 +: 8]),
      .alt_val(ovr_val[p*8 +: 8]),
      .pin_in(pin_in[p*8 +: 8]),
      .pin_out(pin_out_d[p*8 +: 8]),
      .pin_oe(pin_oe_d[p*8 +: 8]),
      .pin_pu(pin_pu_d[p*8 +: 8]),
      .pin_ttl(pin_ttl_d[p*8 +: 8]),
      .pin_ana(pin_ana_d[p*8 +: 8]),
      .rd_view(rd_view[p])
    );
  end

  // --------------------------------------------------
  // Pin and function outputs, registered
  // --------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_q <= '0;
      pin_oe_q <= RST_PIN_OE;
      pin_pu_q <= '0;
      pin_ttl_q <= '0;
      pin_ana_q <= RST_PIN_ANA;
      alt_in_q <= '0;
    end
    else
    begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pin_pu_q <= pin_pu_d;
      pin_ttl_q <= pin_ttl_d;
      pin_ana_q <= pin_ana_d;
      alt_in_q <= alt_in_d;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_pullup_en = pin_pu_q;
  assign pin_ttl_sel = pin_ttl_q;
  assign pin_analog_sel = pin_ana_q;
  assign alt_in = alt_in_q;

  // --------------------------------------------------
  // Read mux, data in the cycle after the strobe
  // --------------------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    for (int p = 0; p < NP; p++)
    begin
      if (hit(reg_addr, mpc_pkg::GRP_DATA, p))
        rdata_d = rd_view[p];
      if (hit(reg_addr, mpc_pkg::GRP_DIR, p))
        rdata_d = dir_q[p];
      if (hit(reg_addr, mpc_pkg::GRP_PULL, p))
        rdata_d = pull_q[p];
      if (hit(reg_addr, mpc_pkg::GRP_TTL, p))
        rdata_d = ttl_q[p];
      if (hit(reg_addr, mpc_pkg::GRP_ODRN, p))
        rdata_d = odrn_q[p];
      if (hit(reg_addr, mpc_pkg::GRP_MODE, p))
        rdata_d = port_mode_control_bits_q[p];
    end
    if (reg_addr == mpc_pkg::OFS_ANALOG_CFG)
      rdata_d = analog_port_config_q;
    if (reg_addr == mpc_pkg::OFS_REDIR)
      rdata_d = peripheral_redirection_control_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// [logic/mpc_redirect.sv]
// Steering of redirectable peripheral functions to their pins
`timescale 1ns/100ps
`default_nettype none
module mpc_redirect (
  input wire logic [mpc_pkg::NRED-1:0] redir,
  input wire logic [mpc_pkg::NRED-1:0] alt_oe,
  input wire logic [mpc_pkg::NRED-1:0] alt_out,
  input wire logic [mpc_pkg::NPIN-1:0] pin_in,
  output logic [mpc_pkg::NPIN-1:0] ovr_en,
  output logic [mpc_pkg::NPIN-1:0] ovr_val,
  output logic [mpc_pkg::NRED-1:0] alt_in
);
  function automatic logic [6:0] pick(input int g, input logic sel);
    pick = sel ? mpc_pkg::RED_SEC[g] : mpc_pkg::RED_PRI[g];
  endfunction
  // --------------------------------------------------
  // Route each function to one pin only
  // --------------------------------------------------
  always_comb
  begin
    ovr_en = '0;
    ovr_val = '0;
    alt_in = '0;
    for (int g = 0; g < mpc_pkg::NRED; g++)
    begin
      alt_in[g] = pin_in[pick(g, redir[g])];
      if (alt_oe[g])
      begin
        ovr_en[pick(g, redir[g])] = 1'b1;
        ovr_val[pick(g, redir[g])] = alt_out[g];
      end
    end
  end
endmodule
`default_nettype wire
